/* File: cbt_defines.vh */
// Purpose: Constants for the boost/thermal and misc control register pair
// Assumes: Register indices are coined; no address map is printed for them
// Notes:   Level codes are in millivolts, percent or degrees Celsius
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH

`define CBT_ADDR_W           4
`define CBT_IDX_BOOST_THERM  4'h6
`define CBT_IDX_MISC         4'h7

`define CBT_BT_RESET         8'h73
`define CBT_MISC_RESET       8'h4b

`define CBT_BV_MSB           7
`define CBT_BV_LSB           4
`define CBT_BH_MSB           3
`define CBT_BH_LSB           2
`define CBT_TR_MSB           1
`define CBT_TR_LSB           0

`define CBT_MISC_FPD         7
`define CBT_MISC_SLOW        6
`define CBT_MISC_BSW         5
`define CBT_MISC_MASK_CHG    1
`define CBT_MISC_MASK_BAT    0

`define CBT_RDATA_NONE       8'h00

`define CBT_BOOST_BASE_MV    13'h11c6
`define CBT_BOOST_STEP_MV    13'h040

`define CBT_BH_LVL_A         2'h0
`define CBT_BH_LVL_B         2'h1
`define CBT_BH_LVL_C         2'h2
`define CBT_BH_OFF           2'h3
`define CBT_PCT_A            6'h21
`define CBT_PCT_B            6'h24
`define CBT_PCT_C            6'h1e

`define CBT_TR_CODE_60       2'h0
`define CBT_TR_CODE_80       2'h1
`define CBT_TR_CODE_100      2'h2
`define CBT_DIE_TEMP_REG_THRESHOLD_60          7'h3c
`define CBT_DIE_TEMP_REG_THRESHOLD_80          7'h50
`define CBT_DIE_TEMP_REG_THRESHOLD_100         7'h64
`define CBT_DIE_TEMP_REG_THRESHOLD_120         7'h78

`endif

/* File: cbt_regs.v */
// Purpose: Boost/thermal control and misc operation control registers
// Assumes: Host reaches them through a decoded single-cycle access port
// Notes:   Decoded settings go straight to the analog control inputs
// Operation
// - Boost voltage code gives 4.55 V plus 64/128/256/512 mV weights, reset 0111.
// - Hot-threshold select 00, 01, 10 picks 33%, 36%, 30% of regulator rail.
// - Hot-threshold select 11 runs boost with no temperature cutoff.
// - With select 11 the thermistor fault still compares at the 00 level.
// - Die threshold codes 00..11 give 60, 80, 100 and 120 degrees C.
// - Boost/thermal register resets to 0111_00_11, all bits read/write.
// - Misc register resets to 01001011, all bits read/write.
// - Misc bits: 7 force detect, 6 timer slow, 5 switch off, 4:2 spare, 1:0 masks.
// - Force detect bit clears itself once port detection finishes.
// - Mask bit 1 enables charge-fault interrupt, bit 0 battery-fault.
// - Timer slow bit halves safety timer during input or thermal regulation.
`timescale 1ns/100ps
`include "cbt_defines.vh"

module cbt_regs (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  input  wire [`CBT_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  output reg  [7:0]             reg_rdata,
  input  wire                   port_detect_done,
  input  wire                   batt_temp_hot_a,
  input  wire                   batt_temp_hot_b,
  input  wire                   batt_temp_hot_c,
  input  wire                   input_reg_active,
  input  wire                   thermal_reg_active,
  input  wire                   charge_fault_evt,
  input  wire                   battery_fault_evt,
  output wire [3:0]             boost_voltage_code,
  output wire [12:0]            boost_target_mv,
  output reg  [5:0]             boost_hot_pct,
  output wire                   boost_temp_mon_en,
  output reg                    boost_temp_disable,
  output reg                    thermistor_fault,
  output wire [1:0]             die_temp_reg_threshold,
  output reg  [6:0]             die_temp_limit_c,
  output wire                   force_port_detect,
  output wire                   safety_timer_half,
  output wire                   battery_switch_off,
  output wire                   fault_int_req
);

  // Access port: a strobe is taken at the rising edge it stands at;
  // write data lands in the register at that edge, and read data
  // is registered at that same edge and holds until the next read
  reg  [7:0] boost_thermal_control_r;
  reg  [7:0] boost_thermal_control_nxt;
  reg  [7:0] misc_operation_control_r;
  reg  [7:0] misc_operation_control_nxt;
  reg  [7:0] reg_rdata_nxt;

  // Decoded access strobes
  wire       wr_bt;
  wire       wr_misc;
  wire       rd_bt;
  wire       rd_misc;

  // Status terms
  wire [1:0] bh_sel;
  wire       slow_en;
  wire       regulating;
  wire       chg_int;
  wire       bat_int;

  // Index match, shared by the write and the read decode so both
  // sides always agree on which register is addressed
  function idx_hit;
    input [`CBT_ADDR_W-1:0] addr;
    input [`CBT_ADDR_W-1:0] idx;
    begin
      idx_hit = (addr == idx);
    end
  endfunction

  // Boost target is the base plus one step per code count; the binary
  // weights 64..512 mV fall out of the multiply
  function [12:0] boost_mv_of;
    input [3:0] code;
    begin
      boost_mv_of = `CBT_BOOST_BASE_MV +
        (`CBT_BOOST_STEP_MV * {9'h000, code});
    end
  endfunction

  // Select 11 falls to the code 00 level so the fault report still works
  function [5:0] hot_pct_of;
    input [1:0] sel;
    begin
      case (sel)
        `CBT_BH_LVL_B: hot_pct_of = `CBT_PCT_B;
        `CBT_BH_LVL_C: hot_pct_of = `CBT_PCT_C;
        default:       hot_pct_of = `CBT_PCT_A;
      endcase
    end
  endfunction

  // Die limit in degrees Celsius per threshold code
  function [6:0] die_limit_of;
    input [1:0] code;
    begin
      case (code)
        `CBT_TR_CODE_60:  die_limit_of = `CBT_DIE_TEMP_REG_THRESHOLD_60;
        `CBT_TR_CODE_80:  die_limit_of = `CBT_DIE_TEMP_REG_THRESHOLD_80;
        `CBT_TR_CODE_100: die_limit_of = `CBT_DIE_TEMP_REG_THRESHOLD_100;
        default:          die_limit_of = `CBT_DIE_TEMP_REG_THRESHOLD_120;
      endcase
    end
  endfunction

  assign wr_bt   = reg_wr & idx_hit(reg_addr, `CBT_IDX_BOOST_THERM);
  assign wr_misc = reg_wr & idx_hit(reg_addr, `CBT_IDX_MISC);
  assign rd_bt   = reg_rd & idx_hit(reg_addr, `CBT_IDX_BOOST_THERM);
  assign rd_misc = reg_rd & idx_hit(reg_addr, `CBT_IDX_MISC);
  assign bh_sel  = boost_thermal_control_r[`CBT_BH_MSB:`CBT_BH_LSB];

  // Boost/thermal register: plain read/write byte
  always @* begin
    boost_thermal_control_nxt = boost_thermal_control_r;
    if (wr_bt) begin
      boost_thermal_control_nxt = reg_wdata;
    end
  end

  // Misc register: the self-clear comes first so a host write of 1 in the
  // same cycle as detection done wins and the new request is not lost.
  // Reserved bits 4:2 are stored and read back but drive nothing.
  always @* begin
    misc_operation_control_nxt = misc_operation_control_r;
    if (port_detect_done) begin
      misc_operation_control_nxt[`CBT_MISC_FPD] = 1'b0;
    end
    if (wr_misc) begin
      misc_operation_control_nxt = reg_wdata;
    end
  end

  // Read data holds between reads; an unmapped index reads as zero.
  // A read in the same cycle as a write returns the old value.
  always @* begin
    reg_rdata_nxt = reg_rdata;
    if (rd_bt) begin
      reg_rdata_nxt = boost_thermal_control_r;
    end else if (rd_misc) begin
      reg_rdata_nxt = misc_operation_control_r;
    end else if (reg_rd) begin
      reg_rdata_nxt = `CBT_RDATA_NONE;
    end
  end

  // Synchronous reset loads the power-on defaults
  always @(posedge clk) begin
    if (!rst_n) begin
      boost_thermal_control_r  <= `CBT_BT_RESET;
      misc_operation_control_r <= `CBT_MISC_RESET;
      reg_rdata                <= `CBT_RDATA_NONE;
    end else begin
      boost_thermal_control_r  <= boost_thermal_control_nxt;
      misc_operation_control_r <= misc_operation_control_nxt;
      reg_rdata                <= reg_rdata_nxt;
    end
  end

  // Code fields straight from the register bits
  assign boost_voltage_code =
    boost_thermal_control_r[`CBT_BV_MSB:`CBT_BV_LSB];
  assign boost_target_mv = boost_mv_of(boost_voltage_code);

  // Level in percent of the internal regulator rail
  always @* begin
    boost_hot_pct = hot_pct_of(bh_sel);
  end

  // Monitoring off only removes the boost cutoff; the fault compare stays
  assign boost_temp_mon_en = (bh_sel != `CBT_BH_OFF);

  // Comparator picked by the select; select 11 reuses the 00 level
  always @* begin
    case (bh_sel)
      `CBT_BH_LVL_A: thermistor_fault = batt_temp_hot_a;
      `CBT_BH_LVL_B: thermistor_fault = batt_temp_hot_b;
      `CBT_BH_LVL_C: thermistor_fault = batt_temp_hot_c;
      default:       thermistor_fault = batt_temp_hot_a;
    endcase
    boost_temp_disable = boost_temp_mon_en & thermistor_fault;
  end

  // Die threshold code is passed to the thermal loop as is
  assign die_temp_reg_threshold =
    boost_thermal_control_r[`CBT_TR_MSB:`CBT_TR_LSB];

  always @* begin
    die_temp_limit_c = die_limit_of(die_temp_reg_threshold);
  end

  // Timer slowdown only matters while a regulation loop is active
  assign slow_en           = misc_operation_control_r[`CBT_MISC_SLOW];
  assign regulating        = input_reg_active | thermal_reg_active;
  assign safety_timer_half = slow_en & regulating;

  // Masks gate the fault levels; the interrupt pin logic lies elsewhere
  assign chg_int = misc_operation_control_r[`CBT_MISC_MASK_CHG] &
    charge_fault_evt;
  assign bat_int = misc_operation_control_r[`CBT_MISC_MASK_BAT] &
    battery_fault_evt;
  assign fault_int_req = chg_int | bat_int;

  // Switch-off and force detect go straight out to the power stage
  assign force_port_detect =
    misc_operation_control_r[`CBT_MISC_FPD];
  assign battery_switch_off =
    misc_operation_control_r[`CBT_MISC_BSW];

endmodule // cbt_regs

/* File: cbt_regs_sva.sv */
// Purpose: Port assertions for the control register pair
// Assumes: One clock, synchronous active-low reset
// Notes:   Decode of target and die limit is judged here only
`timescale 1ns/100ps
module cbt_regs_sva (
  input wire        clk,
  input wire        rst_n,
  input wire        reg_wr,
  input wire        port_detect_done,
  input wire        force_port_detect,
  input wire        boost_temp_mon_en,
  input wire        boost_temp_disable,
  input wire        safety_timer_half,
  input wire        input_reg_active,
  input wire        thermal_reg_active,
  input wire [3:0]  boost_voltage_code,
  input wire [5:0]  boost_hot_pct,
  input wire [12:0] boost_target_mv,
  input wire [6:0]  die_temp_limit_c,
  input wire [1:0]  die_temp_reg_threshold
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_boost_mv: assert property (boost_target_mv ==
    13'd4550 + 13'd64 * boost_voltage_code) else $error("target");
  a_hot_levels: assert property (boost_temp_mon_en |->
    boost_hot_pct inside {6'd33, 6'd36, 6'd30}) else $error("level");
  a_no_cutoff: assert property (!boost_temp_mon_en |->
    !boost_temp_disable) else $error("cutoff");
  a_fault_level: assert property (!boost_temp_mon_en |->
    boost_hot_pct == 6'd33) else $error("fault level");
  a_die_limit: assert property (die_temp_limit_c ==
    7'd60 + 7'd20 * die_temp_reg_threshold) else $error("die limit");
  a_reset_load: assert property ($rose(rst_n) |->
    {boost_voltage_code, die_temp_reg_threshold} == 6'h1f) else $error("rst");
  a_detect_clear: assert property (port_detect_done && !reg_wr &&
    force_port_detect |=> !force_port_detect) else $error("detect");
  a_timer_idle: assert property (!input_reg_active &&
    !thermal_reg_active |-> !safety_timer_half) else $error("timer");
endmodule // cbt_regs_sva

/* File: cbt_host.sv */
// Purpose: Host model for register reads and writes
// Assumes: One-cycle strobes launched just after a rising edge
// Notes:   Idle write data is inverted so a stale byte never passes
`timescale 1ns/100ps
module cbt_host (
  input  wire       clk,
  input  wire [7:0] reg_rdata,
  output reg        reg_wr    = 1'b0,
  output reg        reg_rd    = 1'b0,
  output reg  [3:0] reg_addr  = 4'h0,
  output reg  [7:0] reg_wdata = 8'h00
);
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
  endtask
  task rd(input [3:0] a, output [7:0] d);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) d = reg_rdata;
  endtask
endmodule // cbt_host

/* File: charger_boost_thermal_ctrl_regs_tb.sv */
// Purpose: Self-checking bench for the control register pair
// Assumes: Host model drives the access port
// Notes:   Sweeps every boost code so the checker sees each decode
`timescale 1ns/100ps
module charger_boost_thermal_ctrl_regs_tb;
  reg clk = 0, rst_n = 0, port_detect_done = 0, batt_temp_hot_a = 0;
  reg batt_temp_hot_b = 0, batt_temp_hot_c = 0, input_reg_active = 0;
  reg thermal_reg_active = 0, charge_fault_evt = 0, battery_fault_evt = 0;
  wire reg_wr, reg_rd, boost_temp_mon_en, boost_temp_disable, thermistor_fault;
  wire force_port_detect, safety_timer_half, battery_switch_off, fault_int_req;
  wire [7:0] reg_wdata, reg_rdata;
  wire [3:0] reg_addr, boost_voltage_code;
  wire [12:0] boost_target_mv;
  wire [6:0] die_temp_limit_c;
  wire [5:0] boost_hot_pct;
  wire [1:0] die_temp_reg_threshold;
  reg [7:0] v;
  integer failures = 0, comparisons = 0, cycles = 0, i;
  always #5 clk = ~clk;
  always @(posedge clk) if (++cycles == 3000) wrap_up(1);
  cbt_regs cbt_regs_inst (.*);
  cbt_host cbt_host_inst (.*);
  task chk(input [63:0] n, input [12:0] e, g);
    comparisons += 1;
    failures += (g !== e);
    if (g !== e) $display("CHECK FAILED %0s exp %h got %h", n, e, g);
  endtask
  task wrap_up(input integer t);
    failures += t;
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_boost;
    cbt_host_inst.rd(4'h6, v);
    chk("bt_rst", 8'h73, v);
    @(posedge clk) batt_temp_hot_a <= 1'b1;
    for (i = 0; i < 16; i += 1) begin
      cbt_host_inst.wr(4'h6, {i[3:0], i[3:0]});
      @(negedge clk);
      chk("pct", i[3:2] == 1 ? 36 : (i[3:2] == 2 ? 30 : 33),
        boost_hot_pct);
      chk("ntc", i[3:2] == 0 || i[3:2] == 3, thermistor_fault);
      chk("bdis", i[3:2] == 0, boost_temp_disable);
    end
  endtask
  task t_misc;
    cbt_host_inst.rd(4'h7, v);
    chk("misc_rst", 8'h4b, v);
    @(posedge clk) {input_reg_active, charge_fault_evt} <= 2'b11;
    cbt_host_inst.wr(4'h7, 8'hfe);
    cbt_host_inst.rd(4'h7, v);
    chk("misc_rw", 8'hfe, v);
    chk("misc_out", 4'hf, {force_port_detect, safety_timer_half,
      battery_switch_off, fault_int_req});
    cbt_host_inst.wr(4'h7, 8'h81);
    @(negedge clk);
    chk("masked", 0, {safety_timer_half, fault_int_req});
    @(posedge clk) {port_detect_done, battery_fault_evt} <= 2'b11;
    @(posedge clk) port_detect_done <= 1'b0;
    @(negedge clk);
    chk("fpd_clr", 0, force_port_detect);
    chk("bat_int", 1, fault_int_req);
    @(posedge clk) {input_reg_active, thermal_reg_active} <= 2'b01;
    cbt_host_inst.wr(4'h7, 8'h40);
    @(negedge clk);
    chk("tmr_thm", 1, safety_timer_half);
    cbt_host_inst.wr(4'h5, 8'hff);
    cbt_host_inst.rd(4'h5, v);
    chk("unmapped", 0, v);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_boost;
    t_misc;
    wrap_up(0);
  end
endmodule // charger_boost_thermal_ctrl_regs_tb
bind cbt_regs cbt_regs_sva cbt_regs_sva_inst (.*);
